/* File: verilog/tpd_pkg.sv */
// Package of offsets, reset values, field positions and modes for the three-phase decoder
package tpd_pkg;
	localparam int          TPD_ADDR_W     = 8;
	localparam int          TPD_DATA_W     = 32;
	localparam int          TPD_SENSE_W    = 8;
	localparam int          TPD_FAULT_N    = 4;
	localparam int          TPD_SER_BITS   = 16;
	// APB byte offsets
	localparam logic [7:0]  TPD_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  TPD_OFF_ILIM   = 8'h04;
	localparam logic [7:0]  TPD_OFF_STAT   = 8'h08;
	localparam logic [7:0]  TPD_OFF_STRAP  = 8'h0C;
	localparam logic [7:0]  TPD_OFF_INTST  = 8'h10;
	localparam logic [7:0]  TPD_OFF_INTEN  = 8'h14;
	localparam logic [7:0]  TPD_OFF_INTCLR = 8'h18;
	// Serial register addresses
	localparam logic [5:0]  TPD_SER_STAT   = 6'h00;
	localparam logic [5:0]  TPD_SER_CTRL   = 6'h01;
	// Reset values
	localparam logic [1:0]  TPD_MODE_RST   = 2'h0;
	localparam logic [7:0]  TPD_ILIM_RST   = 8'h80;
	localparam logic [2:0]  TPD_INTEN_RST  = 3'h0;
	// Interrupt bit positions
	localparam int          TPD_INT_FAULT  = 0;
	localparam int          TPD_INT_LIMIT  = 1;
	localparam int          TPD_INT_SERWR  = 2;
	// Mode field codes
	typedef enum logic [1:0] {
		TPD_MODE_6X    = 2'h0,
		TPD_MODE_6X_CL = 2'h1,
		TPD_MODE_3X    = 2'h2,
		TPD_MODE_3X_CL = 2'h3
	} tpd_mode_e;
endpackage : tpd_pkg

/* File: verilog/tpd_phase.sv */
// One half-bridge command decoder with current-limit high-side suppression
`timescale 1ns/1ps
module tpd_phase (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] mode,
	input  wire logic       hi_cmd,
	input  wire logic       lo_cmd,
	input  wire logic       over_limit,
	output logic            hs_on,
	output logic            ls_on
);
	import tpd_pkg::*;

	logic hs_nxt, ls_nxt, hi_d_r, sup_r, sup_nxt, dec_hs, dec_ls, cl;

	always_comb begin
		cl = mode[0];
		// Suppression holds until the next rising high-side command; a new trip wins
		sup_nxt = cl & ((over_limit & hi_cmd) | (sup_r & ~(hi_cmd & ~hi_d_r)));
		if (mode[1]) begin
			dec_hs = lo_cmd & hi_cmd;
			dec_ls = lo_cmd & ~hi_cmd;
		end else begin
			dec_hs = hi_cmd & ~lo_cmd;
			dec_ls = lo_cmd & ~hi_cmd;
		end
		hs_nxt = dec_hs & ~sup_nxt;
		ls_nxt = dec_ls;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_d_r <= 1'b0;
			sup_r  <= 1'b0;
			hs_on  <= 1'b0;
			ls_on  <= 1'b0;
		end else begin
			hi_d_r <= hi_cmd;
			sup_r  <= sup_nxt;
			hs_on  <= hs_nxt;
			ls_on  <= ls_nxt;
		end
	end

	property p_six_hiz;
		@(posedge pclk) disable iff (!presetn)
		(mode[1] == 1'b0 && hi_cmd == lo_cmd) |=> (!hs_on && !ls_on);
	endproperty
	a_six_hiz: assert property (p_six_hiz) else $error("6x equal commands not Hi-Z");

	property p_six_low;
		@(posedge pclk) disable iff (!presetn)
		(mode[1] == 1'b0 && lo_cmd && !hi_cmd) |=> (ls_on && !hs_on);
	endproperty
	a_six_low: assert property (p_six_low) else $error("6x low command not driven low");

	property p_three_hiz;
		@(posedge pclk) disable iff (!presetn)
		(mode[1] && !lo_cmd) |=> (!hs_on && !ls_on);
	endproperty
	a_three_hiz: assert property (p_three_hiz) else $error("3x low-side 0 not Hi-Z");

	property p_three_follow;
		@(posedge pclk) disable iff (!presetn)
		(mode == TPD_MODE_3X && lo_cmd) |=> (hs_on == $past(hi_cmd) && ls_on == !$past(hi_cmd));
	endproperty
	a_three_follow: assert property (p_three_follow) else $error("3x output not following high-side");

	sequence s_trip;
		mode[0] && over_limit && hi_cmd;
	endsequence
	sequence s_held;
		(hi_cmd && mode[0]) [*3];
	endsequence
	property p_suppress;
		@(posedge pclk) disable iff (!presetn)
		s_trip ##1 s_held |-> !hs_on;
	endproperty
	a_suppress: assert property (p_suppress) else $error("high side driven after limit trip");
endmodule : tpd_phase

/* File: verilog/tpd_serial.sv */
// Serial configuration port: 16-bit frames, open-drain data out
`timescale 1ns/1ps
module tpd_serial (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       enable,
	input  wire logic       sclk,
	input  wire logic       sdi,
	input  wire logic       sel_n,
	input  wire logic [7:0] status_byte,
	input  wire logic [7:0] rd_data,
	output logic      [5:0] rd_addr,
	output logic            wr_stb,
	output logic      [5:0] wr_addr,
	output logic      [7:0] wr_data,
	output logic            sdo_oe
);
	import tpd_pkg::*;

	logic        sclk_d_r, sclk_d_nxt, active, fall, wr_stb_nxt, oe_nxt;
	logic [4:0]  cnt_r, cnt_nxt;
	logic [15:0] in_r, in_nxt, out_r, out_nxt;
	logic [5:0]  wr_addr_nxt;
	logic [7:0]  wr_data_nxt;

	assign rd_addr = in_r[5:0];

	always_comb begin
		active      = enable & ~sel_n;
		fall        = sclk_d_r & ~sclk;
		sclk_d_nxt  = sclk;
		cnt_nxt     = cnt_r;
		in_nxt      = in_r;
		out_nxt     = out_r;
		wr_stb_nxt  = 1'b0;
		wr_addr_nxt = wr_addr;
		wr_data_nxt = wr_data;
		if (!active) begin
			cnt_nxt = 5'h00;
			in_nxt  = 16'h0000;
			out_nxt = {status_byte, 8'h00};
		end else if (fall) begin
			in_nxt  = {in_r[14:0], sdi};
			out_nxt = {out_r[14:0], 1'b0};
			cnt_nxt = cnt_r + 5'h01;
			if (cnt_r == 5'h07)
				out_nxt = {rd_data, 8'h00};
			if (cnt_r == 5'h0F && !in_r[14]) begin
				wr_stb_nxt  = 1'b1;
				wr_addr_nxt = in_r[13:8];
				wr_data_nxt = {in_r[6:0], sdi};
			end
		end
		oe_nxt = active & ~out_nxt[15];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_d_r <= 1'b0;
			cnt_r    <= 5'h00;
			in_r     <= 16'h0000;
			out_r    <= 16'h0000;
			wr_stb   <= 1'b0;
			wr_addr  <= 6'h00;
			wr_data  <= 8'h00;
			sdo_oe   <= 1'b0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
			cnt_r    <= cnt_nxt;
			in_r     <= in_nxt;
			out_r    <= out_nxt;
			wr_stb   <= wr_stb_nxt;
			wr_addr  <= wr_addr_nxt;
			wr_data  <= wr_data_nxt;
			sdo_oe   <= oe_nxt;
		end
	end

	property p_idle_release;
		@(posedge pclk) disable iff (!presetn)
		!(enable && !sel_n) |=> !sdo_oe && !wr_stb;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("serial port active while deselected");
endmodule : tpd_serial

/* File: verilog/tpd_top.sv */
// Three-phase command decoder top: pin sync, mode select, straps, serial and APB registers, interrupt
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module tpd_top (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic [tpd_pkg::TPD_ADDR_W-1:0]  paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [tpd_pkg::TPD_DATA_W-1:0]  pwdata,
	output logic      [tpd_pkg::TPD_DATA_W-1:0]  prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic [2:0]                      high_side_command,
	input  wire logic [2:0]                      low_side_command,
	input  wire logic [7:0]                      cfg_pin_lvl,
	input  wire logic                            variant_strapped,
	input  wire logic [tpd_pkg::TPD_FAULT_N-1:0] fault_src,
	input  wire logic [tpd_pkg::TPD_SENSE_W-1:0] sense_a,
	input  wire logic [tpd_pkg::TPD_SENSE_W-1:0] sense_b,
	input  wire logic [tpd_pkg::TPD_SENSE_W-1:0] sense_c,
	output logic      [2:0]                      phase_hs_on,
	output logic      [2:0]                      phase_ls_on,
	output logic                                 limit_cmp_enable,
	output logic                                 fault_indicator_n,
	output logic                                 sdo_out,
	output logic                                 sdo_oe,
	output logic                                 irq,
	output logic      [7:0]                      strap_settings
);
	import tpd_pkg::*;

	localparam int SYNC_W = 6 + 8 + 1 + TPD_FAULT_N;

	function automatic logic [TPD_SENSE_W-1:0] umax(input logic [TPD_SENSE_W-1:0] a, input logic [TPD_SENSE_W-1:0] b);
		umax = (a > b) ? a : b;
	endfunction

	// Two-flop synchronisers for every pin input except the sense buses; left running in reset so straps are valid at release
	logic [SYNC_W-1:0] sync1_r, sync2_r;
	always_ff @(posedge pclk) begin
		sync1_r <= {fault_src, variant_strapped, cfg_pin_lvl, low_side_command, high_side_command};
		sync2_r <= sync1_r;
	end

	logic [2:0]             hi_s, lo_s;
	logic [7:0]             lvl_s;
	logic                   var_s;
	logic [TPD_FAULT_N-1:0] flt_s;
	assign hi_s  = sync2_r[2:0];
	assign lo_s  = sync2_r[5:3];
	assign lvl_s = sync2_r[13:6];
	assign var_s = sync2_r[14];
	assign flt_s = sync2_r[SYNC_W-1:15];

	// Straps caught once after reset release; pin order clk/gain, sdi/slew, sdo/mode, sel/overcurrent
	logic       strap_done_r, strap_done_nxt, variant_r, variant_nxt;
	logic [7:0] strap_nxt;
	always_comb begin
		strap_done_nxt = 1'b1;
		variant_nxt    = strap_done_r ? variant_r : var_s;
		strap_nxt      = strap_settings;
		if (!strap_done_r)
			strap_nxt = var_s ? lvl_s : 8'h00;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_r   <= 1'b0;
			variant_r      <= 1'b0;
			strap_settings <= 8'h00;
		end else begin
			strap_done_r   <= strap_done_nxt;
			variant_r      <= variant_nxt;
			strap_settings <= strap_nxt;
		end
	end

	// Active scheme from the strap or the mode field
	logic [1:0] mode_r, mode_nxt, act_mode;
	assign act_mode = variant_r ? strap_settings[5:4] : mode_r;

	// Serial port on the shared pins, digital level is the upper level bit
	logic       ser_wr, ser_en;
	logic [5:0] ser_rd_addr, ser_wr_addr;
	logic [7:0] ser_wr_data, ser_rd_data, stat_byte;
	assign ser_en = strap_done_r & ~variant_r;
	always_comb begin
		stat_byte   = {1'b0, variant_r, act_mode, flt_s};
		ser_rd_data = 8'h00;
		if (ser_rd_addr == TPD_SER_STAT)
			ser_rd_data = stat_byte;
		else if (ser_rd_addr == TPD_SER_CTRL)
			ser_rd_data = {6'h00, mode_r};
	end
	tpd_serial u_serial (
		.pclk        (pclk),
		.presetn     (presetn),
		.enable      (ser_en),
		.sclk        (lvl_s[1]),
		.sdi         (lvl_s[3]),
		.sel_n       (lvl_s[7]),
		.status_byte (stat_byte),
		.rd_data     (ser_rd_data),
		.rd_addr     (ser_rd_addr),
		.wr_stb      (ser_wr),
		.wr_addr     (ser_wr_addr),
		.wr_data     (ser_wr_data),
		.sdo_oe      (sdo_oe)
	);

	// Current-limit comparator over the largest sense magnitude
	logic                   cl_en, over_r, over_nxt;
	logic [TPD_SENSE_W-1:0] ilim_r, ilim_nxt;
	always_comb begin
		cl_en    = act_mode[0];
		over_nxt = cl_en & (umax(umax(sense_a, sense_b), sense_c) > ilim_r);
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			tpd_phase u_phase (
				.pclk       (pclk),
				.presetn    (presetn),
				.mode       (act_mode),
				.hi_cmd     (hi_s[g]),
				.lo_cmd     (lo_s[g]),
				.over_limit (over_r),
				.hs_on      (phase_hs_on[g]),
				.ls_on      (phase_ls_on[g])
			);
		end
	endgenerate

	// APB slave, zero wait states
	logic        apb_wr, pready_nxt, pslverr_nxt, fault_any;
	logic [31:0] prdata_nxt;
	logic [2:0]  int_st_r, int_st_nxt, int_en_r, int_en_nxt, int_ev;
	logic        flt_d_r;
	assign apb_wr    = psel & penable & pwrite & pready;
	assign fault_any = |flt_s;

	always_comb begin
		pready_nxt  = psel & ~penable;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h0000_0000;
		if (paddr == TPD_OFF_CTRL)
			prdata_nxt = {30'h0, mode_r};
		else if (paddr == TPD_OFF_ILIM)
			prdata_nxt = {24'h0, ilim_r};
		else if (paddr == TPD_OFF_STAT)
			prdata_nxt = {20'h0, phase_ls_on, phase_hs_on, over_r, cl_en, variant_r, fault_any, act_mode};
		else if (paddr == TPD_OFF_STRAP)
			prdata_nxt = {24'h0, strap_settings};
		else if (paddr == TPD_OFF_INTST)
			prdata_nxt = {29'h0, int_st_r};
		else if (paddr == TPD_OFF_INTEN)
			prdata_nxt = {29'h0, int_en_r};
		else if (paddr == TPD_OFF_INTCLR)
			prdata_nxt = 32'h0000_0000;
		else
			pslverr_nxt = psel & ~penable;
		if (!(psel & ~penable))
			prdata_nxt = 32'h0000_0000;
	end

	always_comb begin
		mode_nxt   = mode_r;
		ilim_nxt   = ilim_r;
		int_en_nxt = int_en_r;
		int_st_nxt = int_st_r;
		if (apb_wr && paddr == TPD_OFF_CTRL)
			mode_nxt = pwdata[1:0];
		else if (apb_wr && paddr == TPD_OFF_ILIM)
			ilim_nxt = pwdata[TPD_SENSE_W-1:0];
		else if (apb_wr && paddr == TPD_OFF_INTEN)
			int_en_nxt = pwdata[2:0];
		else if (apb_wr && paddr == TPD_OFF_INTCLR)
			int_st_nxt = int_st_r & ~pwdata[2:0];
		if (ser_wr && ser_wr_addr == TPD_SER_CTRL)
			mode_nxt = ser_wr_data[1:0];
		int_ev                = 3'h0;
		int_ev[TPD_INT_FAULT] = fault_any & ~flt_d_r;
		int_ev[TPD_INT_LIMIT] = over_nxt & ~over_r;
		int_ev[TPD_INT_SERWR] = ser_wr;
		int_st_nxt            = int_st_nxt | int_ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready            <= 1'b0;
			pslverr           <= 1'b0;
			prdata            <= 32'h0000_0000;
			mode_r            <= TPD_MODE_RST;
			ilim_r            <= TPD_ILIM_RST;
			int_en_r          <= TPD_INTEN_RST;
			int_st_r          <= 3'h0;
			flt_d_r           <= 1'b0;
			over_r            <= 1'b0;
			irq               <= 1'b0;
			limit_cmp_enable  <= 1'b0;
			fault_indicator_n <= 1'b1;
			sdo_out           <= 1'b0;
		end else begin
			pready            <= pready_nxt;
			pslverr           <= pslverr_nxt;
			prdata            <= prdata_nxt;
			mode_r            <= mode_nxt;
			ilim_r            <= ilim_nxt;
			int_en_r          <= int_en_nxt;
			int_st_r          <= int_st_nxt;
			flt_d_r           <= fault_any;
			over_r            <= over_nxt;
			irq               <= |(int_st_nxt & int_en_nxt);
			limit_cmp_enable  <= cl_en;
			fault_indicator_n <= ~fault_any;
			sdo_out           <= 1'b0;
		end
	end

	property p_cl_enable;
		@(posedge pclk) disable iff (!presetn)
		##1 (limit_cmp_enable == $past(act_mode[0]));
	endproperty
	a_cl_enable: assert property (p_cl_enable) else $error("limit comparator enable wrong for mode");

	property p_no_limit_6x;
		@(posedge pclk) disable iff (!presetn)
		(act_mode[0] == 1'b0) |=> !over_r;
	endproperty
	a_no_limit_6x: assert property (p_no_limit_6x) else $error("limit trip outside limit scheme");

	property p_fault_pin;
		@(posedge pclk) disable iff (!presetn)
		(fault_src != '0) [*4] |-> !fault_indicator_n;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault not reported on fault output");

	property p_sdo_low_only;
		@(posedge pclk) disable iff (!presetn)
		sdo_oe |-> (sdo_out == 1'b0 && !variant_r);
	endproperty
	a_sdo_low_only: assert property (p_sdo_low_only) else $error("data out driven high or in strapped variant");

	property p_strap_mode;
		@(posedge pclk) disable iff (!presetn)
		(strap_done_r && variant_r) |-> (act_mode == strap_settings[5:4]);
	endproperty
	a_strap_mode: assert property (p_strap_mode) else $error("strapped scheme not applied");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(irq == |(int_st_r & int_en_r));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt output mismatch");

	property p_strap_hold;
		@(posedge pclk) disable iff (!presetn)
		strap_done_r |=> ($stable(strap_settings) && $stable(variant_r));
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("straps changed after capture");

	property p_fault_clear;
		@(posedge pclk) disable iff (!presetn)
		(fault_src == '0) [*4] |-> fault_indicator_n;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault output low without fault");

	property p_pready_once;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_pready_once: assert property (p_pready_once) else $error("ready not a single access cycle");

	property p_int_sticky;
		@(posedge pclk) disable iff (!presetn)
		(int_st_r[TPD_INT_FAULT] && !(apb_wr && paddr == TPD_OFF_INTCLR)) |=> int_st_r[TPD_INT_FAULT];
	endproperty
	a_int_sticky: assert property (p_int_sticky) else $error("fault status lost without clear");

	property p_ser_mode;
		@(posedge pclk) disable iff (!presetn)
		(ser_wr && ser_wr_addr == TPD_SER_CTRL) |=> (mode_r == $past(ser_wr_data[1:0]));
	endproperty
	a_ser_mode: assert property (p_ser_mode) else $error("serial scheme write not applied");
endmodule : tpd_top

/* File: test/tpd_ctl_model.sv */
// Controller-side model of the serial configuration port
`timescale 1ns/1ps
module tpd_ctl_model (
	input  wire logic pclk,
	input  wire logic sdo_line,
	output logic      sclk,
	output logic      sdi,
	output logic      sel_n
);
	localparam int HALF = 5;
	// Serial clock stands low between frames
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		sel_n = 1'b1;
	end
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		rx = '0;
		@(posedge pclk);
		sel_n <= 1'b0;
		repeat (HALF) @(posedge pclk);
		for (int i = 15; i >= 0; i--) begin
			rx[i] = sdo_line;
			sclk <= 1'b1;
			sdi <= tx[i];
			repeat (HALF) @(posedge pclk);
			sclk <= 1'b0;
			repeat (HALF) @(posedge pclk);
		end
		sel_n <= 1'b1;
	endtask : frame
endmodule : tpd_ctl_model

/* File: test/tpd_top_test.sv */
// Self-checking bench for the three-phase command decoder
`timescale 1ns/1ps
module tpd_top_test;
	import tpd_pkg::*;
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] hi;
		logic [2:0] lo;
		logic [2:0] hs;
		logic [2:0] ls;
	} tpd_row_s;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = '0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  hi_cmd = '0;
	logic [2:0]  lo_cmd = '0;
	logic [2:0]  hs_on;
	logic [2:0]  ls_on;
	logic [7:0]  strap_val = 8'hB4;
	logic [7:0]  cfg_pin_lvl;
	logic [7:0]  strap_settings;
	logic        strapped = 1'b0;
	logic [3:0]  fault_src = '0;
	logic [7:0]  sense_a = '0;
	logic [7:0]  sense_b = '0;
	logic [7:0]  sense_c = '0;
	logic        cl_en;
	logic        fault_n;
	logic        sdo_oe;
	logic        sdo_out;
	logic        irq;
	logic        sclk;
	logic        sdi;
	logic        sel_n;
	logic        sdo_line;
	logic [31:0] rd;
	logic        err;
	logic [15:0] rx;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;
	tpd_row_s    rows [8] = '{
		'{2'h0, 3'h0, 3'h0, 3'h0, 3'h0},
		'{2'h0, 3'h3, 3'h5, 3'h2, 3'h4},
		'{2'h0, 3'h7, 3'h7, 3'h0, 3'h0},
		'{2'h1, 3'h6, 3'h3, 3'h4, 3'h1},
		'{2'h2, 3'h3, 3'h6, 3'h2, 3'h4},
		'{2'h2, 3'h5, 3'h7, 3'h5, 3'h2},
		'{2'h3, 3'h4, 3'h5, 3'h4, 3'h1},
		'{2'h2, 3'h7, 3'h0, 3'h0, 3'h0}
	};
	// Pull-up on the shared data pin
	assign sdo_line = sdo_oe ? sdo_out : 1'b1;
	assign cfg_pin_lvl = strapped ? strap_val : {sel_n, sel_n, sdo_line, sdo_line, sdi, sdi, sclk, sclk};
	always #25 pclk = ~pclk;
	tpd_top tpd_top_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.high_side_command(hi_cmd), .low_side_command(lo_cmd), .cfg_pin_lvl(cfg_pin_lvl),
		.variant_strapped(strapped), .fault_src(fault_src), .sense_a(sense_a), .sense_b(sense_b),
		.sense_c(sense_c), .phase_hs_on(hs_on), .phase_ls_on(ls_on), .limit_cmp_enable(cl_en),
		.fault_indicator_n(fault_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .irq(irq), .strap_settings(strap_settings)
	);
	tpd_ctl_model tpd_ctl_model_inst (.pclk(pclk), .sdo_line(sdo_line), .sclk(sclk), .sdi(sdi), .sel_n(sel_n));
	task automatic print_verdict();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd & mask, exp);
	endtask : rd_chk
	initial begin
		tick(4);
		presetn <= 1'b1;
		tick(2);
		rd_chk(TPD_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rd_chk(TPD_OFF_ILIM, 32'hFFFFFFFF, 32'h80);
		rd_chk(TPD_OFF_INTEN, 32'hFFFFFFFF, 32'h0);
		chk(32'(strap_settings), 32'h0);
		apb(8'h1C, 1'b0, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("Reset and register test done");
		foreach (rows[i]) begin
			hi_cmd <= '0;
			lo_cmd <= '0;
			tick(4);
			apb(TPD_OFF_CTRL, 1'b1, 32'(rows[i].mode));
			hi_cmd <= rows[i].hi;
			lo_cmd <= rows[i].lo;
			tick(4);
			chk(32'(hs_on), 32'(rows[i].hs));
			chk(32'(ls_on), 32'(rows[i].ls));
			chk(32'(cl_en), 32'(rows[i].mode[0]));
			rd_chk(TPD_OFF_STAT, 32'h3, 32'(rows[i].mode));
		end
		$display("Decode table test done");
		hi_cmd <= '0;
		lo_cmd <= '0;
		tick(4);
		apb(TPD_OFF_CTRL, 1'b1, 32'h1);
		apb(TPD_OFF_ILIM, 1'b1, 32'h40);
		hi_cmd <= 3'h1;
		tick(4);
		sense_a <= 8'h40;
		tick(4);
		chk(32'(hs_on), 32'h1);
		sense_c <= 8'h41;
		tick(4);
		chk(32'(hs_on), 32'h0);
		chk(32'(ls_on), 32'h0);
		sense_a <= 8'h0;
		sense_c <= 8'h0;
		tick(4);
		chk(32'(hs_on), 32'h0);
		hi_cmd <= 3'h0;
		tick(4);
		hi_cmd <= 3'h1;
		tick(5);
		chk(32'(hs_on), 32'h1);
		sense_b <= 8'h90;
		tick(4);
		chk(32'(hs_on), 32'h0);
		sense_b <= 8'h0;
		hi_cmd <= 3'h0;
		tick(4);
		$display("Current limit test done");
		rd_chk(TPD_OFF_INTST, 32'h2, 32'h2);
		chk(32'(irq), 32'h0);
		apb(TPD_OFF_INTEN, 1'b1, 32'h2);
		tick(2);
		chk(32'(irq), 32'h1);
		apb(TPD_OFF_INTCLR, 1'b1, 32'h2);
		tick(2);
		chk(32'(irq), 32'h0);
		apb(TPD_OFF_INTEN, 1'b1, 32'h1);
		fault_src <= 4'h4;
		tick(5);
		chk(32'(fault_n), 32'h0);
		chk(32'(irq), 32'h1);
		fault_src <= 4'h0;
		tick(5);
		chk(32'(fault_n), 32'h1);
		chk(32'(irq), 32'h1);
		apb(TPD_OFF_INTCLR, 1'b1, 32'h1);
		tick(2);
		chk(32'(irq), 32'h0);
		$display("Interrupt test done");
		tpd_ctl_model_inst.frame({1'b0, TPD_SER_CTRL, 1'b0, 8'h02}, rx);
		tick(8);
		rd_chk(TPD_OFF_STAT, 32'h3, 32'h2);
		rd_chk(TPD_OFF_INTST, 32'h4, 32'h4);
		tpd_ctl_model_inst.frame({1'b1, TPD_SER_CTRL, 1'b0, 8'h00}, rx);
		chk(32'(rx), 32'h2002);
		tick(4);
		chk(32'(sdo_oe), 32'h0);
		chk(32'(sdo_out), 32'h0);
		$display("Serial port test done");
		strapped <= 1'b1;
		tick(1);
		presetn <= 1'b0;
		tick(4);
		presetn <= 1'b1;
		tick(4);
		chk(32'(strap_settings), 32'hB4);
		chk(32'(cl_en), 32'h1);
		rd_chk(TPD_OFF_STAT, 32'hF, 32'hB);
		fault_src <= 4'h1;
		tick(5);
		chk(32'(fault_n), 32'h0);
		chk(32'(sdo_oe), 32'h0);
		$display("Strapped variant test done");
		print_verdict();
	end
endmodule : tpd_top_test
